// ==== rtl/csb_pkg.sv ====
// Constants, register map and operation codes of the shift, subtract,
// bank and pointer execution block.
// Assumes nothing of its surroundings; imported by every design file.
package csb_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned BUS_W = 32;
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned IDX_W = 8;
   localparam int unsigned BE_W = 4;

   // ------------------------------------------------------------
   // Opcodes
   // ------------------------------------------------------------
   localparam logic [7:0] OPC_RRC_R = 8'hC0;
   localparam logic [7:0] OPC_RRC_IR = 8'hC1;
   localparam logic [7:0] OPC_SB0 = 8'h4F;
   localparam logic [7:0] OPC_SB1 = 8'h5F;
   localparam logic [7:0] OPC_SBC_RR = 8'h32;
   localparam logic [7:0] OPC_SBC_RIR = 8'h33;
   localparam logic [7:0] OPC_SBC_GRR = 8'h34;
   localparam logic [7:0] OPC_SBC_GRIR = 8'h35;
   localparam logic [7:0] OPC_SBC_IM = 8'h36;
   localparam logic [7:0] OPC_SCF = 8'hDF;
   localparam logic [7:0] OPC_SRA_R = 8'hD0;
   localparam logic [7:0] OPC_SRA_IR = 8'hD1;
   localparam logic [7:0] OPC_SRP = 8'h31;

   // ------------------------------------------------------------
   // Flag register bit positions
   // ------------------------------------------------------------
   localparam int unsigned FLAG_C = 7;
   localparam int unsigned FLAG_Z = 6;
   localparam int unsigned FLAG_S = 5;
   localparam int unsigned FLAG_V = 4;
   localparam int unsigned FLAG_D = 3;
   localparam int unsigned FLAG_H = 2;
   localparam int unsigned FLAG_BANK = 0;

   // ------------------------------------------------------------
   // Pointer load selection and fields
   // ------------------------------------------------------------
   localparam logic [1:0] SRP_SEL_ZERO = 2'b10;
   localparam logic [1:0] SRP_SEL_ONE = 2'b01;
   localparam logic [1:0] SRP_SEL_BOTH = 2'b00;
   localparam logic [1:0] SRP_SEL_NONE = 2'b11;
   localparam int unsigned PTR_TOP = 7;
   localparam int unsigned PTR_BASE = 3;
   localparam int unsigned PTR_BOTH_BASE = 4;
   localparam int unsigned PTR_LOW_TOP = 2;
   localparam logic PTR0_BOTH_BIT = 1'b0;
   localparam logic PTR1_BOTH_BIT = 1'b1;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_OPCODE = 8'h00;
   localparam logic [7:0] IDX_DST = 8'h01;
   localparam logic [7:0] IDX_SRC = 8'h02;
   localparam logic [7:0] IDX_FLAGS = 8'h03;
   localparam logic [7:0] IDX_RESULT = 8'h04;
   localparam logic [7:0] IDX_STATUS = 8'h05;
   localparam logic [7:0] IDX_PTR0 = 8'hD6;
   localparam logic [7:0] IDX_PTR1 = 8'hD7;
   localparam int unsigned IDX_LSB = 2;

   // ------------------------------------------------------------
   // Status bits and reset values
   // ------------------------------------------------------------
   localparam int unsigned STAT_DECODED = 0;
   localparam int unsigned STAT_DST_WR = 1;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] PTR0_RST = 8'h00;
   localparam logic [7:0] PTR1_RST = 8'h00;
   localparam logic [1:0] STAT_RST = 2'h0;

   // ------------------------------------------------------------
   // Operation classes
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_RRC = 3'b001,
      OP_SB0 = 3'b010,
      OP_SB1 = 3'b011,
      OP_SBC = 3'b100,
      OP_SCF = 3'b101,
      OP_SRA = 3'b110,
      OP_SRP = 3'b111
   } csb_op_type;

endpackage : csb_pkg

// ==== rtl/csb_shift_unit.sv ====
// One-bit right shifter: rotate through carry or arithmetic shift.
// Assumes operands from logic on the same clock; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module csb_shift_unit
   import csb_pkg::*;
(
   // Operands
   input wire logic [DATA_W-1:0] dst_i,
   input wire logic carry_i,
   input wire logic arith_i,
   // Results
   output logic [DATA_W-1:0] result_o,
   output logic carry_o,
   output logic overflow_o
);

   logic top_bit;

   always_comb begin
      top_bit = arith_i ? dst_i[DATA_W-1] : carry_i;
      result_o = {top_bit, dst_i[DATA_W-1:1]};
      carry_o = dst_i[0];
      // Sign change on rotate, always clear on arithmetic shift
      overflow_o = arith_i ? 1'b0 : (dst_i[DATA_W-1] ^ top_bit);
   end

endmodule : csb_shift_unit
`default_nettype wire

// ==== rtl/csb_sbc_unit.sv ====
// Subtract with borrow by adding the complement of the source.
// Assumes operands from logic on the same clock; purely combinational.
`timescale 1ns/10ps
`default_nettype none
module csb_sbc_unit
   import csb_pkg::*;
(
   // Operands
   input wire logic [DATA_W-1:0] dst_i,
   input wire logic [DATA_W-1:0] src_i,
   input wire logic carry_i,
   // Results
   output logic [DATA_W-1:0] result_o,
   output logic borrow_o,
   output logic half_borrow_o,
   output logic overflow_o
);

   // Low nibble width, for the half borrow
   localparam int unsigned NIB_W = 4;

   logic [DATA_W:0] sum;
   logic [NIB_W:0] low_sum;

   always_comb begin
      // dst + ~src + 1 - c equals dst + ~src + ~c
      sum = {1'b0, dst_i} + {1'b0, ~src_i}
         + {{DATA_W{1'b0}}, ~carry_i};
      low_sum = {1'b0, dst_i[NIB_W-1:0]} + {1'b0, ~src_i[NIB_W-1:0]}
         + {{NIB_W{1'b0}}, ~carry_i};
      result_o = sum[DATA_W-1:0];
      borrow_o = ~sum[DATA_W];
      half_borrow_o = ~low_sum[NIB_W];
      overflow_o = (dst_i[DATA_W-1] ^ src_i[DATA_W-1])
         & (sum[DATA_W-1] == src_i[DATA_W-1]);
   end

endmodule : csb_sbc_unit
`default_nettype wire

// ==== rtl/csb_exec.sv ====
// Execution block for rotate through carry, bank select, subtract with
// borrow, set carry, arithmetic shift and register pointer loads.
// Assumes an Avalon-MM master on clk_sys_i; one access at a time.
//
// Contract
// - Rotate: bit 0 to carry, carry to bit 7
// - Rotate shifts down; overflow on sign change
// - Select bank zero clears flag bit 0
// - Select bank one sets flag bit 0
// - Subtract dst minus src minus carry
// - Add source complement; source never modified
// - Carry flag marks a borrow
// - Overflow on sign rule; sign on negative
// - Decimal flag set; half flag marks nibble borrow
// - Set carry forces carry, nothing else
// - Arithmetic shift right keeps bit 7
// - Shift flags: carry from bit 0, zero and sign from result, overflow cleared
// - Pointer load selected by source bits 1:0
// - Both pointers: bit 3 forced 0 and 1
// - Pointers at locations D6 and D7
`timescale 1ns/10ps
`default_nettype none
module csb_exec
   import csb_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [BUS_W-1:0] avs_writedata_i,
   input wire logic [BE_W-1:0] avs_byteenable_i,
   output logic [BUS_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Core state
   output logic bank_sel_o,
   output logic [DATA_W-1:0] working_pointer_zero_o,
   output logic [DATA_W-1:0] working_pointer_one_o
);

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   logic ack;
   logic [IDX_W-1:0] idx;
   logic wr_go;
   logic rd_go;
   logic lane0;

   assign idx = avs_address_i[ADDR_W-1:IDX_LSB];
   assign lane0 = avs_byteenable_i[0];
   assign wr_go = avs_write_i & ack;
   assign rd_go = avs_read_i & ~ack;
   // One wait state on every access
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read_i | avs_write_i) & ~ack;
      end
   end

   // ------------------------------------------------------------
   // Programmer state
   // ------------------------------------------------------------
   logic [DATA_W-1:0] dst_val;
   logic [DATA_W-1:0] src_val;
   logic [DATA_W-1:0] flags;
   logic [DATA_W-1:0] result;
   logic [1:0] status;
   logic [DATA_W-1:0] working_pointer_zero;
   logic [DATA_W-1:0] working_pointer_one;

   logic wr_lane;
   logic exec;
   logic [DATA_W-1:0] wbyte;

   assign wr_lane = wr_go & lane0;
   assign wbyte = avs_writedata_i[DATA_W-1:0];
   assign exec = wr_lane & (idx == IDX_OPCODE);

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   csb_op_type op_kind;

   always_comb begin
      op_kind = OP_NONE;
      unique case (wbyte)
         OPC_RRC_R, OPC_RRC_IR: begin
            op_kind = OP_RRC;
         end
         OPC_SB0: begin
            op_kind = OP_SB0;
         end
         OPC_SB1: begin
            op_kind = OP_SB1;
         end
         OPC_SBC_RR, OPC_SBC_RIR, OPC_SBC_GRR, OPC_SBC_GRIR,
            OPC_SBC_IM: begin
            op_kind = OP_SBC;
         end
         OPC_SCF: begin
            op_kind = OP_SCF;
         end
         OPC_SRA_R, OPC_SRA_IR: begin
            op_kind = OP_SRA;
         end
         OPC_SRP: begin
            op_kind = OP_SRP;
         end
         default: begin
            op_kind = OP_NONE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Datapath units
   // ------------------------------------------------------------
   logic [DATA_W-1:0] shift_result;
   logic shift_carry;
   logic shift_ovf;
   logic [DATA_W-1:0] sbc_result;
   logic sbc_borrow;
   logic sbc_half;
   logic sbc_ovf;

   csb_shift_unit u_shift (
      .dst_i(dst_val),
      .carry_i(flags[FLAG_C]),
      .arith_i(op_kind == OP_SRA),
      .result_o(shift_result),
      .carry_o(shift_carry),
      .overflow_o(shift_ovf)
   );

   csb_sbc_unit u_sbc (
      .dst_i(dst_val),
      .src_i(src_val),
      .carry_i(flags[FLAG_C]),
      .result_o(sbc_result),
      .borrow_o(sbc_borrow),
      .half_borrow_o(sbc_half),
      .overflow_o(sbc_ovf)
   );

   // ------------------------------------------------------------
   // Next destination and flags
   // ------------------------------------------------------------
   logic [DATA_W-1:0] next_dst;
   logic [DATA_W-1:0] next_flags;
   logic dst_upd;

   always_comb begin
      next_dst = dst_val;
      next_flags = flags;
      dst_upd = 1'b0;
      unique case (op_kind)
         OP_RRC, OP_SRA: begin
            next_dst = shift_result;
            dst_upd = 1'b1;
            next_flags[FLAG_C] = shift_carry;
            next_flags[FLAG_Z] = (shift_result == BYTE_RST);
            next_flags[FLAG_S] = shift_result[DATA_W-1];
            next_flags[FLAG_V] = shift_ovf;
         end
         OP_SBC: begin
            next_dst = sbc_result;
            dst_upd = 1'b1;
            next_flags[FLAG_C] = sbc_borrow;
            next_flags[FLAG_Z] = (sbc_result == BYTE_RST);
            next_flags[FLAG_S] = sbc_result[DATA_W-1];
            next_flags[FLAG_V] = sbc_ovf;
            next_flags[FLAG_D] = 1'b1;
            next_flags[FLAG_H] = sbc_half;
         end
         OP_SB0: begin
            next_flags[FLAG_BANK] = 1'b0;
         end
         OP_SB1: begin
            next_flags[FLAG_BANK] = 1'b1;
         end
         OP_SCF: begin
            next_flags[FLAG_C] = 1'b1;
         end
         OP_SRP, OP_NONE: begin
            next_flags = flags;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Operand registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         dst_val <= BYTE_RST;
      end else if (exec && dst_upd) begin
         dst_val <= next_dst;
      end else if (wr_lane && idx == IDX_DST) begin
         dst_val <= wbyte;
      end
   end

   // Source is only ever loaded by software
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         src_val <= BYTE_RST;
      end else if (wr_lane && idx == IDX_SRC) begin
         src_val <= wbyte;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         result <= BYTE_RST;
      end else if (exec && dst_upd) begin
         result <= next_dst;
      end
   end

   // ------------------------------------------------------------
   // Flags and status
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         flags <= BYTE_RST;
      end else if (exec) begin
         flags <= next_flags;
      end else if (wr_lane && idx == IDX_FLAGS) begin
         flags <= wbyte;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         status <= STAT_RST;
      end else if (exec) begin
         status[STAT_DECODED] <= (op_kind != OP_NONE);
         status[STAT_DST_WR] <= dst_upd;
      end
   end

   // ------------------------------------------------------------
   // Register pointers
   // ------------------------------------------------------------
   logic srp_go;
   logic [1:0] srp_sel;

   assign srp_go = exec && (op_kind == OP_SRP);
   assign srp_sel = src_val[1:0];

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         working_pointer_zero <= PTR0_RST;
      end else if (srp_go) begin
         if (srp_sel == SRP_SEL_ZERO) begin
            working_pointer_zero[PTR_TOP:PTR_BASE] <=
               src_val[PTR_TOP:PTR_BASE];
         end else if (srp_sel == SRP_SEL_BOTH) begin
            working_pointer_zero[PTR_TOP:PTR_BASE] <=
               {src_val[PTR_TOP:PTR_BOTH_BASE], PTR0_BOTH_BIT};
         end
         // Pattern 11 falls through unchanged
      end else if (wr_lane && idx == IDX_PTR0) begin
         working_pointer_zero <= wbyte;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         working_pointer_one <= PTR1_RST;
      end else if (srp_go) begin
         if (srp_sel == SRP_SEL_ONE) begin
            working_pointer_one[PTR_TOP:PTR_BASE] <=
               src_val[PTR_TOP:PTR_BASE];
         end else if (srp_sel == SRP_SEL_BOTH) begin
            working_pointer_one[PTR_TOP:PTR_BASE] <=
               {src_val[PTR_TOP:PTR_BOTH_BASE], PTR1_BOTH_BIT};
         end
      end else if (wr_lane && idx == IDX_PTR1) begin
         working_pointer_one <= wbyte;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [DATA_W-1:0] rd_byte;

   always_comb begin
      rd_byte = BYTE_RST;
      unique case (idx)
         IDX_DST: begin
            rd_byte = dst_val;
         end
         IDX_SRC: begin
            rd_byte = src_val;
         end
         IDX_FLAGS: begin
            rd_byte = flags;
         end
         IDX_RESULT: begin
            rd_byte = result;
         end
         IDX_STATUS: begin
            rd_byte = {6'h00, status};
         end
         IDX_PTR0: begin
            rd_byte = working_pointer_zero;
         end
         IDX_PTR1: begin
            rd_byte = working_pointer_one;
         end
         default: begin
            rd_byte = BYTE_RST;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         avs_readdata_o <= {BUS_W{1'b0}};
      end else if (rd_go) begin
         avs_readdata_o <= {24'h000000, rd_byte};
      end
   end

   // ------------------------------------------------------------
   // Core state outputs
   // ------------------------------------------------------------
   assign bank_sel_o = flags[FLAG_BANK];
   assign working_pointer_zero_o = working_pointer_zero;
   assign working_pointer_one_o = working_pointer_one;

endmodule : csb_exec
`default_nettype wire

// ==== bench/csb_exec_assertions.sv ====
// Checker of bus timing, bank flag and pointer registers of csb_exec.
// Assumes it is bound to csb_exec and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module csb_exec_assertions
   import csb_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [BUS_W-1:0] avs_writedata_i,
   input wire logic [BE_W-1:0] avs_byteenable_i,
   input wire logic [BUS_W-1:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Core state
   input wire logic bank_sel_o,
   input wire logic [DATA_W-1:0] working_pointer_zero_o,
   input wire logic [DATA_W-1:0] working_pointer_one_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   logic req;
   logic [7:0] idx;
   logic [7:0] wd;
   assign req = avs_read_i | avs_write_i;
   assign idx = avs_address_i[9:2];
   assign wd = avs_writedata_i[7:0];
   // ---------------------------------------------
   // Committed accesses
   // ---------------------------------------------
   sequence s_wr;
      avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   endsequence
   sequence s_rd;
      avs_read_i && !avs_waitrequest_o;
   endsequence
   a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o
      ##1 !avs_waitrequest_o) else $error("no single wait state");
   a_idle_nowait: assert property (!req |-> !avs_waitrequest_o)
      else $error("waitrequest while idle");
   a_read_upper: assert property (s_rd |-> avs_readdata_o[31:8] == 24'h0)
      else $error("upper read lanes not zero");
   a_ptr0_read: assert property (
      s_rd ##0 (idx == IDX_PTR0) |-> avs_readdata_o[7:0] ==
      working_pointer_zero_o) else $error("pointer zero read wrong");
   a_ptr1_read: assert property (
      s_rd ##0 (idx == IDX_PTR1) |-> avs_readdata_o[7:0] ==
      working_pointer_one_o) else $error("pointer one read wrong");
   a_ptr0_write: assert property (
      s_wr ##0 (idx == IDX_PTR0) |=> working_pointer_zero_o == $past(wd))
      else $error("pointer zero write lost");
   a_ptr1_write: assert property (
      s_wr ##0 (idx == IDX_PTR1) |=> working_pointer_one_o == $past(wd))
      else $error("pointer one write lost");
   a_bank_zero: assert property (
      s_wr ##0 (idx == IDX_OPCODE && wd == OPC_SB0) |=> !bank_sel_o)
      else $error("bank not cleared");
   a_bank_one: assert property (
      s_wr ##0 (idx == IDX_OPCODE && wd == OPC_SB1) |=> bank_sel_o)
      else $error("bank not set");
   a_state_hold: assert property ($past(rst_b_i) && !$past(avs_write_i)
      |-> $stable(working_pointer_zero_o) && $stable(working_pointer_one_o)
      && $stable(bank_sel_o)) else $error("core state moved without write");
endmodule : csb_exec_assertions

bind csb_exec csb_exec_assertions i_csb_chk (.clk_sys_i(clk_sys_i),
   .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .bank_sel_o(bank_sel_o), .working_pointer_zero_o(working_pointer_zero_o),
   .working_pointer_one_o(working_pointer_one_o));
`default_nettype wire

// ==== bench/csb_exec_tb.sv ====
// Self-checking bench of csb_exec: corner and random operations.
// Assumes the design and its checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module csb_exec_tb
   import csb_pkg::*;
   ;
   logic clk_sys_i, rst_b_i, avs_read_i, avs_write_i;
   logic [ADDR_W-1:0] avs_address_i;
   logic [BUS_W-1:0] avs_writedata_i, avs_readdata_o;
   logic [BE_W-1:0] avs_byteenable_i;
   logic avs_waitrequest_o, bank_sel_o;
   logic [7:0] working_pointer_zero_o, working_pointer_one_o;
   logic [7:0] p0, p1, v, res;
   logic [7:0] opt [14];
   logic [31:0] q;
   int bad_count, check_count, cycles;

   csb_exec i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .bank_sel_o(bank_sel_o),
      .working_pointer_zero_o(working_pointer_zero_o),
      .working_pointer_one_o(working_pointer_one_o));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic report_and_stop();
      if (bad_count == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : report_and_stop

   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         $display("[FAIL] %0t timeout", $time);
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // ---------------------------------------------
   // Bus access: one request, held until accepted
   // ---------------------------------------------
   task automatic bus(input logic wr, input logic [7:0] idx,
         input logic [7:0] d, input logic [3:0] be);
      @(posedge clk_sys_i);
      avs_address_i <= {idx, 2'b00};
      avs_writedata_i <= {24'($urandom), d};
      avs_byteenable_i <= be;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus

   task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00, 4'hF);
      chk(q, {24'h0, exp});
   endtask : chk_reg

   function automatic logic [17:0] model(input logic [7:0] o, dv, sv, f);
      logic [8:0] t;
      logic [4:0] h;
      logic [7:0] r, nf;
      logic ar;
      r = dv;
      nf = f;
      ar = 1'b1;
      case (o)
         OPC_RRC_R, OPC_RRC_IR: begin
            r = {f[FLAG_C], dv[7:1]};
            nf[FLAG_C] = dv[0];
            nf[FLAG_V] = dv[7] ^ r[7];
         end
         OPC_SRA_R, OPC_SRA_IR: begin
            r = {dv[7], dv[7:1]};
            nf[FLAG_C] = dv[0];
            nf[FLAG_V] = 1'b0;
         end
         OPC_SBC_RR, OPC_SBC_RIR, OPC_SBC_GRR, OPC_SBC_GRIR, OPC_SBC_IM: begin
            t = {1'b0, dv} - {1'b0, sv} - 9'(f[FLAG_C]);
            h = {1'b0, dv[3:0]} - {1'b0, sv[3:0]} - 5'(f[FLAG_C]);
            r = t[7:0];
            nf[FLAG_C] = t[8];
            nf[FLAG_H] = h[4];
            nf[FLAG_D] = 1'b1;
            nf[FLAG_V] = (dv[7] != sv[7]) && (r[7] == sv[7]);
         end
         default: begin
            ar = 1'b0;
            if (o == OPC_SB0) nf[FLAG_BANK] = 1'b0;
            if (o == OPC_SB1) nf[FLAG_BANK] = 1'b1;
            if (o == OPC_SCF) nf[FLAG_C] = 1'b1;
         end
      endcase
      if (ar) begin
         nf[FLAG_Z] = (r == 8'h00);
         nf[FLAG_S] = r[7];
      end
      return {ar, o != 8'h00, r, nf};
   endfunction : model

   task automatic exec(input logic [7:0] o, dv, sv, fv);
      logic [17:0] e;
      e = model(o, dv, sv, fv);
      bus(1'b1, IDX_DST, dv, 4'hF);
      bus(1'b1, IDX_SRC, sv, 4'hF);
      bus(1'b1, IDX_FLAGS, fv, 4'hF);
      bus(1'b1, IDX_OPCODE, o, 4'hF);
      if (o == OPC_SRP) begin
         case (sv[1:0])
            SRP_SEL_ZERO: p0 = {sv[7:3], p0[2:0]};
            SRP_SEL_ONE: p1 = {sv[7:3], p1[2:0]};
            SRP_SEL_BOTH: begin
               p0 = {sv[7:4], 1'b0, p0[2:0]};
               p1 = {sv[7:4], 1'b1, p1[2:0]};
            end
            default: ;
         endcase
      end
      chk_reg(IDX_DST, e[15:8]);
      chk_reg(IDX_FLAGS, e[7:0]);
      chk_reg(IDX_SRC, sv);
      chk_reg(IDX_STATUS, {6'h0, e[17:16]});
      if (e[17]) res = e[15:8];
      chk_reg(IDX_RESULT, res);
      chk_reg(IDX_PTR0, p0);
      chk_reg(IDX_PTR1, p1);
      chk({31'h0, bank_sel_o}, {31'h0, e[FLAG_BANK]});
      chk({16'h0, working_pointer_one_o, working_pointer_zero_o},
         {16'h0, p1, p0});
   endtask : exec

   initial begin
      opt = '{OPC_RRC_R, OPC_RRC_IR, OPC_SB0, OPC_SB1, OPC_SBC_RR,
         OPC_SBC_RIR, OPC_SBC_GRR, OPC_SBC_GRIR, OPC_SBC_IM, OPC_SCF,
         OPC_SRA_R, OPC_SRA_IR, OPC_SRP, 8'h00};
      {rst_b_i, avs_read_i, avs_write_i} = 3'b000;
      avs_address_i = '0;
      avs_writedata_i = '0;
      avs_byteenable_i = '0;
      {bad_count, check_count, cycles} = '0;
      {p0, p1, res} = 24'h0;
      void'($urandom(12));
      repeat (5) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      chk_reg(IDX_FLAGS, 8'h00);
      exec(OPC_SRP, 8'h00, 8'h40, 8'h00);
      exec(OPC_RRC_R, 8'h55, 8'h00, 8'h00);
      exec(OPC_SRA_R, 8'h9A, 8'h00, 8'h80);
      exec(OPC_SBC_RR, 8'h10, 8'h03, 8'h80);
      exec(OPC_SBC_IM, 8'h00, 8'h00, 8'h80);
      exec(OPC_SBC_IM, 8'h20, 8'h8A, 8'h80);
      for (int i = 0; i < 14; i++) begin
         exec(opt[i], 8'($urandom), 8'($urandom), 8'($urandom));
      end
      // Direct pointer writes, masked lane, unmapped place
      v = 8'($urandom);
      bus(1'b1, IDX_PTR0, v, 4'hF);
      p0 = v;
      bus(1'b1, IDX_PTR1, ~v, 4'hE);
      bus(1'b1, 8'h80, v, 4'hF);
      chk_reg(8'h80, 8'h00);
      chk_reg(IDX_OPCODE, 8'h00);
      for (int i = 0; i < 4; i++) begin
         exec(OPC_SRP, 8'($urandom), {6'($urandom), 2'(i)}, 8'($urandom));
      end
      for (int i = 0; i < 150; i++) begin
         exec(opt[$urandom % 14], 8'($urandom), 8'($urandom), 8'($urandom));
      end
      // Second reset in mid-run
      @(posedge clk_sys_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      {p0, p1, res} = 24'h0;
      chk_reg(IDX_FLAGS, 8'h00);
      chk_reg(IDX_DST, 8'h00);
      chk_reg(IDX_RESULT, 8'h00);
      exec(OPC_SCF, 8'h00, 8'h00, 8'h00);
      report_and_stop();
   end
endmodule : csb_exec_tb
`default_nettype wire
